// ==== hw/asc_pkg.sv ====
// Notes on behaviour
// - One start, one stop, 10 or 11 bits.
// - Length select picks nine or eight bits.
// - Wake on address mark or idle line.
// - Idle count starts after stop or start.
// - Parity sits in most significant position.
// - Parity select one means odd parity.
// - Software keeps parity type steady mid-character.
// - Four enables gate transmit, receive, idle flags.
// - Enabling transmitter sends an all-ones preamble.
// - Disabling transmitter finishes current character first.
// - Off-then-on enable queues one idle character.
// - Transmit and receive enable writes ignored while unit disabled.
// - Receiver disable leaves receive flags untouched.
// - Standby masks receive irqs, wake clears it.
// - Break control sends breaks then one.
// - Early break request replaces the preamble.
// - Received ninth bit captured with data.
// - Ninth transmit bit loads with data.
// - Four enables gate the error interrupt.
// - Reset clears controls, keeps received ninth bit.
// - Unit disable sets empty, complete, masks tx.
// - Waking address mark sets receive full.
// - Waking idle sets neither idle nor full.
`default_nettype none
package asc_pkg;
  // ---------------------------------------------------------------------------
  // Register map, word offsets on the Wishbone bus.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADR_FORMAT = 4'h0;
  localparam logic [3:0] ADR_ENABLE = 4'h1;
  localparam logic [3:0] ADR_NINTH = 4'h2;
  localparam logic [3:0] ADR_STATUS = 4'h3;
  localparam logic [3:0] ADR_DATA = 4'h4;
  localparam logic [3:0] ADR_BAUD = 4'h5;
  // Field positions of the format register.
  localparam int F_UNIT_EN = 5;
  localparam int F_NINE = 4;
  localparam int F_WAKE_ADDR = 3;
  localparam int F_IDLE_AFTER_STOP = 2;
  localparam int F_PAR_EN = 1;
  localparam int F_PAR_ODD = 0;
  // Field positions of the enable register.
  localparam int F_TXE_IE = 7;
  localparam int F_TC_IE = 6;
  localparam int F_RXF_IE = 5;
  localparam int F_IDLE_IE = 4;
  localparam int F_TX_EN = 3;
  localparam int F_RX_EN = 2;
  localparam int F_STANDBY = 1;
  localparam int F_BREAK = 0;
  // Field positions of the ninth-bit register.
  localparam int F_RX9 = 7;
  localparam int F_TX9 = 6;
  // Reset values and defaults.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_BAUD = 16'h0010;
  localparam logic [3:0] FRAME_SHORT = 4'ha;
  localparam logic [3:0] FRAME_LONG = 4'hb;
endpackage
`default_nettype wire

// ==== hw/asc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial link between the controller and the remote node.
interface asc_link_if;
  logic txd;
  logic rxd;
  modport ctrl (output txd, input rxd);
  modport node (input txd, output rxd);
endinterface
`default_nettype wire

// ==== hw/asc_ctrl.sv ====
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic err_irq_o,
  asc_link_if.ctrl link
);
  // ---------------------------------------------------------------------------
  // Registers and bus slave.
  // ---------------------------------------------------------------------------
  logic [7:0] fmt_reg, en_reg, ninth_reg, dat_reg, txd_reg, st_reg;
  logic [15:0] baud_reg;
  logic rx9_reg, tx_pend_reg, tx_busy_reg, txout_reg;
  logic [3:0] err_ie_reg;
  logic ack_reg;
  logic [31:0] rd_reg;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
  wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;
  wire unit_on = fmt_reg[asc_pkg::F_UNIT_EN];
  wire nine = fmt_reg[asc_pkg::F_NINE];
  wire par_en = fmt_reg[asc_pkg::F_PAR_EN];
  wire par_odd = fmt_reg[asc_pkg::F_PAR_ODD];
  wire [3:0] flen = nine ? asc_pkg::FRAME_LONG : asc_pkg::FRAME_SHORT;
  // Status flags, filled in by the receiver and transmitter below.
  logic tx_empty, tx_cmpl, rx_full, idle_f, ovr_f, noise_f, frm_f, par_f;
  logic clr_rx_flags, rx_set_full, rx_set_idle, rx_set_ovr, rx_set_frm, rx_set_par, tx_load;
  logic wake_clr;

  // Ack for one cycle; reads return a snapshot of the addressed register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      case (wb_adr_i)
        asc_pkg::ADR_FORMAT: rd_reg <= {24'h0, fmt_reg};
        asc_pkg::ADR_ENABLE: rd_reg <= {24'h0, en_reg};
        asc_pkg::ADR_NINTH: rd_reg <= {24'h0, rx9_reg, ninth_reg[asc_pkg::F_TX9], 2'b00, err_ie_reg};
        asc_pkg::ADR_STATUS: rd_reg <= {24'h0, tx_empty, tx_cmpl, rx_full, idle_f, ovr_f, noise_f, frm_f, par_f};
        asc_pkg::ADR_DATA: rd_reg <= {24'h0, dat_reg};
        asc_pkg::ADR_BAUD: rd_reg <= {16'h0, baud_reg};
        default: rd_reg <= 32'h0;
      endcase
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  // Control registers; transmit and receive enable bits only move while the unit is on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_reg <= asc_pkg::RST_CTRL;
      en_reg <= asc_pkg::RST_CTRL;
      ninth_reg <= asc_pkg::RST_CTRL;
      err_ie_reg <= 4'h0;
      baud_reg <= asc_pkg::RST_BAUD;
    end else begin
      if (wr && wb_adr_i == asc_pkg::ADR_FORMAT) fmt_reg <= wb_dat_i[7:0];
      if (wr && wb_adr_i == asc_pkg::ADR_ENABLE) begin
        en_reg[7:4] <= wb_dat_i[7:4];
        en_reg[asc_pkg::F_BREAK] <= wb_dat_i[asc_pkg::F_BREAK];
        en_reg[asc_pkg::F_STANDBY] <= wb_dat_i[asc_pkg::F_STANDBY];
        if (unit_on) begin
          en_reg[asc_pkg::F_TX_EN] <= wb_dat_i[asc_pkg::F_TX_EN];
          en_reg[asc_pkg::F_RX_EN] <= wb_dat_i[asc_pkg::F_RX_EN];
        end
      end else if (wake_clr) begin
        en_reg[asc_pkg::F_STANDBY] <= 1'b0;
      end
      if (wr && wb_adr_i == asc_pkg::ADR_NINTH) begin
        ninth_reg[asc_pkg::F_TX9] <= wb_dat_i[asc_pkg::F_TX9];
        err_ie_reg <= wb_dat_i[3:0];
      end
      if (wr && wb_adr_i == asc_pkg::ADR_BAUD) baud_reg <= {wb_dat_i[15:1], 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // Bit-rate enable.
  // ---------------------------------------------------------------------------
  logic [15:0] bcnt_reg;
  logic bit_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_on) begin
      bcnt_reg <= 16'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (bcnt_reg == baud_reg - 16'h1);
      bcnt_reg <= (bcnt_reg == baud_reg - 16'h1) ? 16'h0 : bcnt_reg + 16'h1;
    end
  end
  wire [15:0] half = {1'b0, baud_reg[15:1]};

  // ---------------------------------------------------------------------------
  // Transmitter.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ASC_TX_IDLE, ASC_TX_SHIFT} asc_txs_t;
  asc_txs_t txs_reg;
  logic [10:0] tsh_reg;
  logic [3:0] tcnt_reg;
  logic pre_reg, idle_q_reg, brk_reg, brk_one_reg;
  wire [7:0] tx_par_src = nine ? txd_reg : {1'b0, txd_reg[6:0]};
  wire tpar = ^tx_par_src ^ par_odd;
  wire tx_en = en_reg[asc_pkg::F_TX_EN];
  logic brk_req_reg;
  // A short set-then-clear of the break bit may fall between bit ticks, so the request is held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_req_reg <= 1'b0;
    end else if (wr && wb_adr_i == asc_pkg::ADR_ENABLE && wb_dat_i[asc_pkg::F_BREAK]) begin
      brk_req_reg <= 1'b1;
    end else if (bit_tick && txs_reg == ASC_TX_IDLE && tx_en) begin
      brk_req_reg <= 1'b0;
    end
  end
  wire send_break_ctl = en_reg[asc_pkg::F_BREAK] || brk_req_reg;
  // Data write holds the character and clears the empty flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pend_reg <= 1'b0;
      txd_reg <= 8'h0;
      pre_reg <= 1'b0;
      idle_q_reg <= 1'b0;
    end else begin
      if (wr && wb_adr_i == asc_pkg::ADR_DATA && unit_on) begin
        txd_reg <= wb_dat_i[7:0];
        tx_pend_reg <= 1'b1;
      end else if (tx_load) begin
        tx_pend_reg <= 1'b0;
      end
      if (wr && wb_adr_i == asc_pkg::ADR_ENABLE && unit_on && wb_dat_i[asc_pkg::F_TX_EN] && !tx_en) begin
        if (tx_busy_reg) idle_q_reg <= 1'b1;
        else pre_reg <= 1'b1;
      end else if (txs_reg == ASC_TX_IDLE && bit_tick && (pre_reg || idle_q_reg)) begin
        pre_reg <= 1'b0;
        idle_q_reg <= 1'b0;
      end
    end
  end
  assign tx_busy_reg = (txs_reg != ASC_TX_IDLE);
  assign tx_load = txs_reg == ASC_TX_IDLE && bit_tick && tx_en && tx_pend_reg && !pre_reg && !idle_q_reg && !send_break_ctl &&
                   !brk_one_reg;
  assign tx_empty = !tx_pend_reg || !unit_on;
  assign tx_cmpl = (tx_empty && !tx_busy_reg && !pre_reg && !idle_q_reg) || !unit_on;

  // Shift engine: breaks first, then preamble or idle, then data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txs_reg <= ASC_TX_IDLE;
      tsh_reg <= 11'h7ff;
      tcnt_reg <= 4'h0;
      txout_reg <= 1'b1;
      brk_one_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else if (bit_tick) begin
      case (txs_reg)
        ASC_TX_IDLE: begin
          txout_reg <= 1'b1;
          if (tx_en && send_break_ctl) begin
            tsh_reg <= 11'h0;
            brk_reg <= 1'b1;
            txs_reg <= ASC_TX_SHIFT;
            tcnt_reg <= flen;
          end else if (tx_en && brk_one_reg) begin
            brk_one_reg <= 1'b0;
          end else if (tx_en && (pre_reg || idle_q_reg)) begin
            tsh_reg <= 11'h7ff;
            txs_reg <= ASC_TX_SHIFT;
            tcnt_reg <= flen;
          end else if (tx_load) begin
            // Start, data, optional ninth or parity, stop.
            if (nine) tsh_reg <= {1'b1, par_en ? tpar : ninth_reg[asc_pkg::F_TX9], txd_reg, 1'b0};
            else tsh_reg <= {2'b11, par_en ? tpar : txd_reg[7], txd_reg[6:0], 1'b0};
            txs_reg <= ASC_TX_SHIFT;
            tcnt_reg <= flen;
          end
        end
        ASC_TX_SHIFT: begin
          txout_reg <= tsh_reg[0];
          tsh_reg <= {1'b1, tsh_reg[10:1]};
          tcnt_reg <= tcnt_reg - 4'h1;
          if (tcnt_reg == 4'h1) begin
            txs_reg <= ASC_TX_IDLE;
            if (brk_reg) brk_one_reg <= !send_break_ctl;
            brk_reg <= 1'b0;
          end
        end
        default: txs_reg <= ASC_TX_IDLE;
      endcase
    end
  end
  assign link.txd = txout_reg;

  // ---------------------------------------------------------------------------
  // Receiver.
  // ---------------------------------------------------------------------------
  logic rx_s1_reg, rx_s2_reg, rxbusy_reg, seen_char_reg;
  logic [15:0] rsmp_reg;
  logic [3:0] rbit_reg, ones_reg;
  logic [9:0] rsh_reg;
  wire rx_en = en_reg[asc_pkg::F_RX_EN];
  wire standby = en_reg[asc_pkg::F_STANDBY];
  wire wake_addr = fmt_reg[asc_pkg::F_WAKE_ADDR];
  // Flags clear on a data read, the simple form of the clear sequence.
  assign clr_rx_flags = rd && wb_adr_i == asc_pkg::ADR_DATA;
  always_ff @(posedge clk_i) begin
    rx_s1_reg <= link.rxd;
    rx_s2_reg <= rx_s1_reg;
  end
  // Frame sampling at mid-bit; ones counted for idle detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxbusy_reg <= 1'b0;
      rsmp_reg <= 16'h0;
      rbit_reg <= 4'h0;
      rsh_reg <= 10'h0;
      ones_reg <= 4'h0;
      rx_set_full <= 1'b0;
      rx_set_idle <= 1'b0;
      rx_set_ovr <= 1'b0;
      rx_set_frm <= 1'b0;
      rx_set_par <= 1'b0;
      wake_clr <= 1'b0;
      dat_reg <= 8'h0;
    end else begin
      rx_set_full <= 1'b0;
      rx_set_idle <= 1'b0;
      rx_set_ovr <= 1'b0;
      rx_set_frm <= 1'b0;
      rx_set_par <= 1'b0;
      wake_clr <= 1'b0;
      if (!rx_en || !unit_on) begin
        rxbusy_reg <= 1'b0;
        ones_reg <= 4'h0;
      end else if (!rxbusy_reg) begin
        if (!rx_s2_reg) begin
          rxbusy_reg <= 1'b1;
          rsmp_reg <= 16'h0;
          rbit_reg <= 4'h0;
          if (!fmt_reg[asc_pkg::F_IDLE_AFTER_STOP]) ones_reg <= 4'h0;
        end else if (bit_tick && ones_reg != flen) begin
          ones_reg <= ones_reg + 4'h1;
          if (ones_reg + 4'h1 == flen) begin
            if (standby && !wake_addr) wake_clr <= 1'b1;
            else if (!standby && seen_char_reg) rx_set_idle <= 1'b1;
          end
        end
      end else begin
        rsmp_reg <= (rsmp_reg == baud_reg - 16'h1) ? 16'h0 : rsmp_reg + 16'h1;
        if (rsmp_reg == half) begin
          if (rbit_reg != 4'h0) rsh_reg <= {rx_s2_reg, rsh_reg[9:1]};
          if (!fmt_reg[asc_pkg::F_IDLE_AFTER_STOP] && rbit_reg != 4'h0)
            ones_reg <= rx_s2_reg ? ones_reg + 4'h1 : 4'h0;
          if (rbit_reg == flen - 4'h1) begin
            rxbusy_reg <= 1'b0;
            if (fmt_reg[asc_pkg::F_IDLE_AFTER_STOP]) ones_reg <= 4'h0;
            if (standby && !(wake_addr && rsh_reg[9])) begin
              // Ignored while asleep.
            end else begin
              if (standby) wake_clr <= 1'b1;
              rx_set_frm <= !rx_s2_reg;
              if (rx_full) rx_set_ovr <= 1'b1;
              else begin
                rx_set_full <= 1'b1;
                dat_reg <= nine ? rsh_reg[8:1] : rsh_reg[9:2];
                rx9_reg <= rsh_reg[9];
                rx_set_par <= par_en && ((nine ? ^rsh_reg[9:1] : ^rsh_reg[9:2]) != par_odd);
              end
            end
          end
          rbit_reg <= rbit_reg + 4'h1;
        end
      end
    end
  end
  // Sticky receive flags; a set in the clear cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= 8'h0;
      seen_char_reg <= 1'b0;
    end else begin
      if (clr_rx_flags) st_reg <= 8'h0;
      if (rx_set_full) st_reg[0] <= 1'b1;
      if (rx_set_idle) st_reg[1] <= 1'b1;
      if (rx_set_ovr) st_reg[2] <= 1'b1;
      if (rx_set_frm) st_reg[3] <= 1'b1;
      if (rx_set_par) st_reg[4] <= 1'b1;
      if (rx_set_full) seen_char_reg <= 1'b1;
      else if (rx_set_idle || (clr_rx_flags && st_reg[1])) seen_char_reg <= 1'b0;
    end
  end
  assign rx_full = st_reg[0];
  assign idle_f = st_reg[1];
  assign ovr_f = st_reg[2];
  assign frm_f = st_reg[3];
  assign par_f = st_reg[4];
  assign noise_f = 1'b0;

  // Interrupt request gating, registered.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= unit_on && ((en_reg[asc_pkg::F_TXE_IE] && tx_empty) ||
                  (en_reg[asc_pkg::F_TC_IE] && tx_cmpl));
      rx_irq_o <= !standby && ((en_reg[asc_pkg::F_RXF_IE] && rx_full) ||
                  (en_reg[asc_pkg::F_IDLE_IE] && idle_f));
      err_irq_o <= |(err_ie_reg & {ovr_f, noise_f, frm_f, par_f});
    end
  end
endmodule // asc_ctrl
`default_nettype wire

// ==== hw/asc_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_node #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] tx_data_i,
  input wire logic tx_nine_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [8:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_stop_err_o,
  asc_link_if.node link
);
  // ---------------------------------------------------------------------------
  // Remote node: sends and receives frames of one start and one stop bit.
  // ---------------------------------------------------------------------------
  logic s1_reg, s2_reg, txo_reg, tbusy_reg, rbusy_reg, nine_reg;
  logic [10:0] tsh_reg;
  logic [3:0] tcnt_reg, rcnt_reg;
  logic [15:0] tdiv_reg, rdiv_reg;
  logic [9:0] rsh_reg;
  // Transmit: caller supplies the data bits, parity included.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txo_reg <= 1'b1;
      tbusy_reg <= 1'b0;
      tsh_reg <= 11'h7ff;
      tcnt_reg <= 4'h0;
      tdiv_reg <= 16'h0;
    end else if (!tbusy_reg) begin
      txo_reg <= 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        tbusy_reg <= 1'b1;
        tsh_reg <= tx_nine_i ? {1'b1, tx_data_i, 1'b0} : {2'b11, tx_data_i[7:0], 1'b0};
        tcnt_reg <= tx_nine_i ? 4'hb : 4'ha;
        tdiv_reg <= 16'h0;
      end
    end else begin
      tdiv_reg <= (tdiv_reg == 16'(BIT_CYCLES - 1)) ? 16'h0 : tdiv_reg + 16'h1;
      if (tdiv_reg == 16'h0) begin
        txo_reg <= tsh_reg[0];
        tsh_reg <= {1'b1, tsh_reg[10:1]};
        tcnt_reg <= tcnt_reg - 4'h1;
        if (tcnt_reg == 4'h0) tbusy_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) tx_ready_o <= 1'b0;
    else tx_ready_o <= !tbusy_reg && !(tx_valid_i && tx_ready_o);
  end
  assign link.rxd = txo_reg;
  // Receive, framed by the node's own tx_nine_i length selection.
  always_ff @(posedge clk_i) begin
    s1_reg <= link.txd;
    s2_reg <= s1_reg;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rbusy_reg <= 1'b0;
      rcnt_reg <= 4'h0;
      rdiv_reg <= 16'h0;
      rsh_reg <= 10'h0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 9'h0;
      rx_stop_err_o <= 1'b0;
      nine_reg <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      nine_reg <= tx_nine_i;
      if (!rbusy_reg) begin
        if (!s2_reg) begin
          rbusy_reg <= 1'b1;
          rcnt_reg <= 4'h0;
          rdiv_reg <= 16'h0;
        end
      end else begin
        rdiv_reg <= (rdiv_reg == 16'(BIT_CYCLES - 1)) ? 16'h0 : rdiv_reg + 16'h1;
        if (rdiv_reg == 16'(BIT_CYCLES / 2)) begin
          rcnt_reg <= rcnt_reg + 4'h1;
          if (rcnt_reg != 4'h0) rsh_reg <= {s2_reg, rsh_reg[9:1]};
          if (rcnt_reg == (nine_reg ? 4'ha : 4'h9)) begin
            rbusy_reg <= 1'b0;
            rx_valid_o <= 1'b1;
            rx_stop_err_o <= !s2_reg;
            rx_data_o <= nine_reg ? rsh_reg[9:1] : {1'b0, rsh_reg[9:2]};
          end
        end
      end
    end
  end
endmodule // asc_node
`default_nettype wire

// ==== tb/asc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Link and bus checker for the controller facing the node.
// ---------------------------------------------------------------------------
module asc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic txd,
  input wire logic rxd,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic err_irq_o
);
  // One clock domain, so clocking and reset are given once for all properties.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Both lines rest high and no request is raised straight out of reset.
  property p_rst_idle;
    $fell(rst_i) |-> txd && rxd && !tx_irq_o && !rx_irq_o && !err_irq_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("link or request not idle after reset");
  // A low level on the transmit line is at least half a bit time long.
  property p_tx_low;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_tx_low: assert property (p_tx_low)
    else $error("short low level on transmit line");
  // A high level is never cut short, so a stopped transmitter ends whole bits.
  property p_tx_high;
    $rose(txd) |-> txd [*8];
  endproperty
  a_tx_high: assert property (p_tx_high)
    else $error("short high level on transmit line");
  // The node keeps the same bit timing on its own line.
  property p_rx_low;
    $fell(rxd) |-> !rxd [*8];
  endproperty
  a_rx_low: assert property (p_rx_low)
    else $error("short low level on receive line");
  property p_rx_high;
    $rose(rxd) |-> rxd [*8];
  endproperty
  a_rx_high: assert property (p_rx_high)
    else $error("short high level on receive line");
  // Every access is answered, even one that is ignored.
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("bus access not answered in one cycle");
  property p_ack_single;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("acknowledge longer than one cycle");
  // A full receive buffer appears during the stop bit, while the line is high.
  property p_rx_irq;
    $rose(rx_irq_o) |-> rxd;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive request outside the stop bit");
endmodule // asc_chk
`default_nettype wire

// ==== tb/asc_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Bench: controller and node joined back to back over the serial link.
// ---------------------------------------------------------------------------
module asc_tb_top;
  localparam int BIT = 17;
  localparam logic [3:0] A_FMT = asc_pkg::ADR_FORMAT;
  localparam logic [3:0] A_EN = asc_pkg::ADR_ENABLE;
  localparam logic [3:0] A_N9 = asc_pkg::ADR_NINTH;
  localparam logic [3:0] A_ST = asc_pkg::ADR_STATUS;
  localparam logic [3:0] A_DAT = asc_pkg::ADR_DATA;
  typedef struct packed {
    logic [3:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
  } asc_row_t;
  logic clk_i;
  logic rst_i = 1'h1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tx_irq_o;
  logic rx_irq_o;
  logic err_irq_o;
  logic [8:0] tx_data = 9'h0;
  logic tx_nine = 1'h0;
  logic tx_valid = 1'h0;
  logic tx_ready;
  logic [8:0] rx_data;
  logic rx_valid;
  logic rx_stop_err;
  logic [31:0] q;
  logic [7:0] d = 8'hb3;
  logic [8:0] e;
  logic nine;
  logic par;
  logic odd;
  int n;
  int n_errors = 0;
  int total_checks = 0;
  // Register rows: address, write flag, write data, read mask, expected read.
  asc_row_t rows [10] = '{'{A_FMT, 1'h0, 8'h0, 8'hff, 8'h0}, '{A_EN, 1'h0, 8'h0, 8'hff, 8'h0},
    '{A_N9, 1'h0, 8'h0, 8'h7f, 8'h0}, '{A_ST, 1'h0, 8'h0, 8'hc0, 8'hc0}, '{A_EN, 1'h1, 8'h0c, 8'hff, 8'h0},
    '{4'hf, 1'h1, 8'hff, 8'hff, 8'h0}, '{asc_pkg::ADR_BAUD, 1'h1, 8'h11, 8'hff, 8'h11},
    '{A_FMT, 1'h1, 8'h20, 8'hff, 8'h20}, '{A_EN, 1'h1, 8'h04, 8'hff, 8'h04}, '{A_N9, 1'h1, 8'h4f, 8'h7f, 8'h4f}};
  asc_link_if link();
  asc_ctrl i_asc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o), .link(link));
  asc_node #(.BIT_CYCLES(BIT)) i_asc_node (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data), .tx_nine_i(tx_nine),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_stop_err_o(rx_stop_err), .link(link));
  asc_chk i_asc_chk (.clk_i(clk_i), .rst_i(rst_i), .txd(link.txd), .rxd(link.rxd), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
  // The clock runs free at 200 MHz.
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Classic single cycle; the request holds until ack is seen at a rising edge.
  task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] wd);
    int k;
    k = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    @(posedge clk_i);
    if (k >= 50) fail("bus timeout");
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] ex);
    xfer(a, 1'h0, 8'h0);
    chk(q & {24'h0, m}, {24'h0, ex}, "register read");
  endtask
  // The node sends one character and the bench lets the whole frame pass.
  task automatic node_send(input logic [8:0] nd, input logic nn);
    int k;
    k = 0;
    tx_data <= nd;
    tx_nine <= nn;
    tx_valid <= 1'h1;
    do begin
      @(posedge clk_i);
      k++;
    end while (tx_ready !== 1'h1 && k < 40 * BIT);
    tx_valid <= 1'h0;
    repeat (12 * BIT) @(posedge clk_i);
    if (k >= 40 * BIT) fail("node send timeout");
  endtask
  // Waits for the node's received character; the ninth bit counts in long frames only.
  task automatic node_get(input logic [8:0] ex, input logic nn);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rx_valid !== 1'h1 && k < 40 * BIT);
    chk({23'h0, rx_data & {nn, 8'hff}}, {23'h0, ex & {nn, 8'hff}}, "node data");
    repeat (BIT) @(posedge clk_i);
  endtask
  // Main sequence: register table first, then serial traffic both ways.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].w) xfer(rows[i].a, 1'h1, rows[i].d);
      rd(rows[i].a, rows[i].m, rows[i].e);
    end
    xfer(A_EN, 1'h1, 8'h0c);
    xfer(A_DAT, 1'h1, 8'h5a);
    n = 0;
    while (link.txd !== 1'h0 && n < 40 * BIT) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 10 * BIT - 8), 32'h1, "preamble too short");
    node_get(9'h05a, 1'h0);
    xfer(A_EN, 1'h1, 8'hcc);
    @(posedge clk_i);
    chk({31'h0, tx_irq_o}, 32'h1, "tx request missing");
    xfer(A_EN, 1'h1, 8'h0c);
    @(posedge clk_i);
    chk({31'h0, tx_irq_o}, 32'h0, "tx request not masked");
    // Every format with parity, then a long frame carrying the written ninth bit.
    for (int k = 0; k < 5; k++) begin
      nine = (k >= 2);
      par = (k < 4);
      odd = k[0];
      tx_nine <= nine;
      xfer(A_FMT, 1'h1, {2'h0, 1'h1, nine, 2'h0, par, odd});
      xfer(A_DAT, 1'h1, d);
      e = par ? (nine ? {^d ^ odd, d} : {1'h0, ^d[6:0] ^ odd, d[6:0]}) : {1'h1, d};
      node_get(e, nine);
    end
    xfer(A_EN, 1'h1, 8'h2c);
    node_send(9'h13c, 1'h1);
    chk({31'h0, rx_irq_o}, 32'h1, "rx request missing");
    rd(A_N9, 8'h80, 8'h80);
    rd(A_DAT, 8'hff, 8'h3c);
    chk({31'h0, rx_irq_o}, 32'h0, "rx request not cleared");
    xfer(A_FMT, 1'h1, 8'h20);
    node_send(9'h045, 1'h0);
    rd(A_N9, 8'h80, 8'h00);
    xfer(A_EN, 1'h1, 8'h28);
    rd(A_ST, 8'h20, 8'h20);
    rd(A_DAT, 8'hff, 8'h45);
    // Standby: a character without the address mark is ignored, a marked one wakes.
    xfer(A_FMT, 1'h1, 8'h38);
    xfer(A_EN, 1'h1, 8'h2e);
    node_send(9'h055, 1'h1);
    chk({31'h0, rx_irq_o}, 32'h0, "request during standby");
    rd(A_EN, 8'h02, 8'h02);
    node_send(9'h1aa, 1'h1);
    rd(A_EN, 8'h02, 8'h00);
    chk({31'h0, rx_irq_o}, 32'h1, "address mark not flagged");
    rd(A_DAT, 8'hff, 8'haa);
    // A long frame into a short receiver puts a zero where the stop bit belongs.
    xfer(A_FMT, 1'h1, 8'h20);
    xfer(A_EN, 1'h1, 8'h0c);
    node_send(9'h0f0, 1'h1);
    chk({31'h0, err_irq_o}, 32'h1, "error request missing");
    rd(A_ST, 8'h02, 8'h02);
    xfer(A_N9, 1'h1, 8'h40);
    @(posedge clk_i);
    chk({31'h0, err_irq_o}, 32'h0, "error request not masked");
    rd(A_DAT, 8'h00, 8'h00);
    // One break: the line stays low for exactly one short frame.
    tx_nine <= 1'h0;
    xfer(A_EN, 1'h1, 8'h0d);
    xfer(A_EN, 1'h1, 8'h0c);
    n = 0;
    while (link.txd !== 1'h0 && n < 40 * BIT) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (link.txd === 1'h0 && n < 40 * BIT) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n), 32'(10 * BIT), "break length");
    repeat (2 * BIT) @(posedge clk_i);
    chk({31'h0, rx_stop_err}, 32'h1, "break not seen by node");
    end_sim();
  end
  // The whole run needs well under 20000 cycles; this cuts a hang short.
  initial begin
    #(50000 * 5);
    fail("watchdog expired");
    end_sim();
  end
endmodule // asc_tb_top
`default_nettype wire
